// file: verilog/smcg_pkg.sv
// package of modes, gate vector layout and timing constants for the sleep manager
package smcg_pkg;
	// sleep modes selectable by software (six, no active entry)
	typedef enum logic [2:0] {
		SMCG_MODE_IDLE,
		SMCG_MODE_ADC_NR,
		SMCG_MODE_PWR_DOWN,
		SMCG_MODE_PWR_SAVE,
		SMCG_MODE_STANDBY,
		SMCG_MODE_EXT_STANDBY
	} smcg_mode_type;

	localparam int SMCG_NUM_MODES = 6;

	// bit positions in the enable vector
	localparam int SMCG_EN_CPU   = 0;
	localparam int SMCG_EN_RAM   = 1;
	localparam int SMCG_EN_TIMER = 2;
	localparam int SMCG_EN_SPI   = 3;
	localparam int SMCG_EN_IRQ   = 4;
	localparam int SMCG_EN_IO    = 5;
	localparam int SMCG_EN_ADC   = 6;
	localparam int SMCG_EN_ASYNC = 7;
	localparam int SMCG_EN_XOSC  = 8;
	localparam int SMCG_EN_RCOSC = 9;
	localparam int SMCG_EN_WIDTH = 10;

	// domains cut from supply in deep sleep
	localparam int SMCG_PD_CORE  = 0;
	localparam int SMCG_PD_IO    = 1;
	localparam int SMCG_PD_WIDTH = 2;

	localparam logic [SMCG_EN_WIDTH-1:0] SMCG_EN_ALL   = 10'h3FF;
	localparam logic [SMCG_EN_WIDTH-1:0] SMCG_EN_RESET = 10'h3FF;

	// time from clock restore to cpu release
	localparam int SMCG_RESTORE_NS = 200;
	localparam int SMCG_CLK_NS     = 50;
	localparam int SMCG_RESTORE_CYC = (SMCG_RESTORE_NS + SMCG_CLK_NS - 1) / SMCG_CLK_NS;
	localparam int SMCG_CNT_W = 4;
endpackage : smcg_pkg

// file: verilog/smcg_gate_if.sv
// interface carrying the gate vector between the sequencer and the gate decoder
`timescale 1ns/100ps
interface smcg_gate_if;
	logic                            sleeping;
	logic                            deep;
	smcg_pkg::smcg_mode_type         mode;
	logic                            keep_wdt;
	logic                            keep_symcnt;
	logic                            keep_lfosc;
	logic [smcg_pkg::SMCG_EN_WIDTH-1:0] enables;
	modport seq (output sleeping, output deep, output mode, output keep_wdt,
		output keep_symcnt, output keep_lfosc, input enables);
	modport dec (input sleeping, input deep, input mode, input keep_wdt,
		input keep_symcnt, input keep_lfosc, output enables);
endinterface : smcg_gate_if

// file: verilog/smcg_gate_dec.sv
// decoder from sleep mode to the set of running clocks and oscillators
`timescale 1ns/100ps
module smcg_gate_dec (
	smcg_gate_if.dec g
);
	// map mode onto enable vector
	always_comb begin
		g.enables = smcg_pkg::SMCG_EN_ALL;
		if (g.deep) begin
			g.enables = '0;
		end else if (g.sleeping) begin
			g.enables = '0;
			case (g.mode)
				smcg_pkg::SMCG_MODE_IDLE: begin
					g.enables = smcg_pkg::SMCG_EN_ALL;
					g.enables[smcg_pkg::SMCG_EN_CPU] = 1'b0;
				end
				smcg_pkg::SMCG_MODE_ADC_NR: begin
					g.enables[smcg_pkg::SMCG_EN_ADC]   = 1'b1;
					g.enables[smcg_pkg::SMCG_EN_ASYNC] = 1'b1;
					g.enables[smcg_pkg::SMCG_EN_IRQ]   = 1'b1;
					g.enables[smcg_pkg::SMCG_EN_RAM]   = 1'b1;
					g.enables[smcg_pkg::SMCG_EN_XOSC]  = 1'b1;
					g.enables[smcg_pkg::SMCG_EN_RCOSC] = 1'b1;
				end
				smcg_pkg::SMCG_MODE_PWR_DOWN: begin
					g.enables = '0;
				end
				smcg_pkg::SMCG_MODE_PWR_SAVE: begin
					g.enables[smcg_pkg::SMCG_EN_ASYNC] = 1'b1;
				end
				smcg_pkg::SMCG_MODE_STANDBY: begin
					g.enables[smcg_pkg::SMCG_EN_RCOSC] = 1'b1;
				end
				smcg_pkg::SMCG_MODE_EXT_STANDBY: begin
					g.enables[smcg_pkg::SMCG_EN_RCOSC] = 1'b1;
					g.enables[smcg_pkg::SMCG_EN_ASYNC] = 1'b1;
				end
				default: begin
					g.enables = '0;
				end
			endcase
		end
	end
endmodule : smcg_gate_dec

// file: verilog/smcg_top.sv
// sleep-mode manager: gates clocks, oscillators and supplies per low-power mode
//
// What this block does
// - software picks one of six sleep modes
// - idle stops cpu clock, peripherals keep running
// - power-down keeps registers, stops main oscillator
// - power-save keeps asynchronous timer counting
// - noise reduction keeps adc, async timer, irq, ram and both oscillators
// - standby keeps rc oscillator running
// - extended standby keeps rc oscillator and asynchronous timer
// - deep sleep cuts supply, optional keepers run
`timescale 1ns/100ps
module smcg_top (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [2:0]  mode_sel,
	input  wire logic        sleep_req,
	input  wire logic        deep_req,
	input  wire logic        keep_wdt,
	input  wire logic        keep_symcnt,
	input  wire logic        keep_lfosc,
	input  wire logic        wake_irq,
	output logic             cpu_clk_en,
	output logic             ram_clk_en,
	output logic             timer_clk_en,
	output logic             spi_clk_en,
	output logic             irq_clk_en,
	output logic             io_clk_en,
	output logic             adc_clk_en,
	output logic             async_clk_en,
	output logic             xosc_en,
	output logic             rcosc_en,
	output logic             core_pwr_en,
	output logic             io_pwr_en,
	output logic             wdt_run,
	output logic             symcnt_run,
	output logic             lfosc_run,
	output logic             sleeping,
	output logic             mode_err
);
	typedef enum logic [1:0] {
		SMCG_ST_ACTIVE,
		SMCG_ST_SLEEP,
		SMCG_ST_RESTORE
	} smcg_state_type;

	smcg_gate_if g ();

	smcg_state_type                      state_ff, nxt_state;
	smcg_pkg::smcg_mode_type             mode_ff, nxt_mode;
	logic                                deep_ff, nxt_deep;
	logic                                kwdt_ff, nxt_kwdt;
	logic                                ksym_ff, nxt_ksym;
	logic                                klf_ff, nxt_klf;
	logic                                err_ff, nxt_err;
	logic [smcg_pkg::SMCG_CNT_W-1:0]     cnt_ff, nxt_cnt;
	logic [smcg_pkg::SMCG_EN_WIDTH-1:0]  en_ff, nxt_en;
	logic [smcg_pkg::SMCG_PD_WIDTH-1:0]  pwr_ff, nxt_pwr;
	logic [2:0]                          run_ff, nxt_run;
	logic                                sleep_ff, nxt_sleep;

	localparam logic [smcg_pkg::SMCG_CNT_W-1:0] RESTORE_CNT =
		smcg_pkg::SMCG_CNT_W'(smcg_pkg::SMCG_RESTORE_CYC);

	// legal mode code check
	function automatic logic mode_ok(input logic [2:0] code);
		mode_ok = (32'(code) < smcg_pkg::SMCG_NUM_MODES);
	endfunction : mode_ok

	assign g.sleeping    = (state_ff == SMCG_ST_SLEEP);
	assign g.deep        = (state_ff == SMCG_ST_SLEEP) && deep_ff;
	assign g.mode        = mode_ff;
	assign g.keep_wdt    = kwdt_ff;
	assign g.keep_symcnt = ksym_ff;
	assign g.keep_lfosc  = klf_ff;

	smcg_gate_dec u_dec (
		.g (g)
	);

	// sleep entry, wake and restore sequence
	always_comb begin
		nxt_state = state_ff;
		nxt_mode  = mode_ff;
		nxt_deep  = deep_ff;
		nxt_kwdt  = kwdt_ff;
		nxt_ksym  = ksym_ff;
		nxt_klf   = klf_ff;
		nxt_err   = 1'b0;
		nxt_cnt   = cnt_ff;
		case (state_ff)
			SMCG_ST_ACTIVE: begin
				if (deep_req) begin
					nxt_state = SMCG_ST_SLEEP;
					nxt_deep  = 1'b1;
					nxt_mode  = smcg_pkg::SMCG_MODE_PWR_DOWN;
					nxt_kwdt  = keep_wdt;
					nxt_ksym  = keep_symcnt;
					nxt_klf   = keep_lfosc;
				end else if (sleep_req && mode_ok(mode_sel)) begin
					nxt_state = SMCG_ST_SLEEP;
					nxt_deep  = 1'b0;
					nxt_mode  = smcg_pkg::smcg_mode_type'(mode_sel);
				end else if (sleep_req) begin
					nxt_err = 1'b1; // unknown code refused
				end
			end
			SMCG_ST_SLEEP: begin
				if (wake_irq) begin
					nxt_state = SMCG_ST_RESTORE;
					nxt_deep  = 1'b0;
					nxt_cnt   = RESTORE_CNT;
				end
			end
			SMCG_ST_RESTORE: begin
				if (cnt_ff <= 4'h1) begin
					nxt_state = SMCG_ST_ACTIVE;
					nxt_cnt   = '0;
				end else begin
					nxt_cnt = cnt_ff - 4'h1;
				end
			end
			default: begin
				nxt_state = SMCG_ST_ACTIVE;
			end
		endcase
	end

	// output staging: restore reopens all but cpu until count ends
	always_comb begin
		nxt_en  = g.enables;
		nxt_pwr = '1;
		nxt_run = 3'h0;
		nxt_sleep = (nxt_state == SMCG_ST_SLEEP); // registered copy of the sleep state
		if (nxt_state == SMCG_ST_RESTORE) begin
			nxt_en = smcg_pkg::SMCG_EN_ALL;
			nxt_en[smcg_pkg::SMCG_EN_CPU] = 1'b0;
		end else if (nxt_state == SMCG_ST_ACTIVE) begin
			nxt_en = smcg_pkg::SMCG_EN_ALL;
		end else if (nxt_deep) begin
			nxt_en  = '0;
			nxt_pwr = '0;
			nxt_run = {nxt_klf, nxt_ksym, nxt_kwdt};
		end else begin
			// holding sleep: the decoder already sees the live mode; on entry look one cycle ahead
			nxt_en = (state_ff == SMCG_ST_SLEEP) ? g.enables : en_dec(nxt_mode);
		end
	end

	// enable set for a given sleep mode, mirrors the decoder one cycle ahead
	function automatic logic [smcg_pkg::SMCG_EN_WIDTH-1:0] en_dec(
		input smcg_pkg::smcg_mode_type m);
		logic [smcg_pkg::SMCG_EN_WIDTH-1:0] e;
		e = '0;
		case (m)
			smcg_pkg::SMCG_MODE_IDLE: begin
				e = smcg_pkg::SMCG_EN_ALL;
				e[smcg_pkg::SMCG_EN_CPU] = 1'b0;
			end
			smcg_pkg::SMCG_MODE_ADC_NR: begin
				e[smcg_pkg::SMCG_EN_ADC]   = 1'b1;
				e[smcg_pkg::SMCG_EN_ASYNC] = 1'b1;
				e[smcg_pkg::SMCG_EN_IRQ]   = 1'b1;
				e[smcg_pkg::SMCG_EN_RAM]   = 1'b1;
				e[smcg_pkg::SMCG_EN_XOSC]  = 1'b1;
				e[smcg_pkg::SMCG_EN_RCOSC] = 1'b1;
			end
			smcg_pkg::SMCG_MODE_PWR_SAVE: e[smcg_pkg::SMCG_EN_ASYNC] = 1'b1;
			smcg_pkg::SMCG_MODE_STANDBY: e[smcg_pkg::SMCG_EN_RCOSC] = 1'b1;
			smcg_pkg::SMCG_MODE_EXT_STANDBY: begin
				e[smcg_pkg::SMCG_EN_RCOSC] = 1'b1;
				e[smcg_pkg::SMCG_EN_ASYNC] = 1'b1;
			end
			default: e = '0;
		endcase
		en_dec = e;
	endfunction : en_dec

	// state registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= SMCG_ST_ACTIVE;
			mode_ff  <= smcg_pkg::SMCG_MODE_IDLE;
			deep_ff  <= 1'b0;
			kwdt_ff  <= 1'b0;
			ksym_ff  <= 1'b0;
			klf_ff   <= 1'b0;
			err_ff   <= 1'b0;
			cnt_ff   <= '0;
			en_ff    <= smcg_pkg::SMCG_EN_RESET;
			pwr_ff   <= '1;
			run_ff   <= 3'h0;
			sleep_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			mode_ff  <= nxt_mode;
			deep_ff  <= nxt_deep;
			kwdt_ff  <= nxt_kwdt;
			ksym_ff  <= nxt_ksym;
			klf_ff   <= nxt_klf;
			err_ff   <= nxt_err;
			cnt_ff   <= nxt_cnt;
			en_ff    <= nxt_en;
			pwr_ff   <= nxt_pwr;
			run_ff   <= nxt_run;
			sleep_ff <= nxt_sleep;
		end
	end

	// outputs straight from flip-flops
	assign cpu_clk_en   = en_ff[smcg_pkg::SMCG_EN_CPU];
	assign ram_clk_en   = en_ff[smcg_pkg::SMCG_EN_RAM];
	assign timer_clk_en = en_ff[smcg_pkg::SMCG_EN_TIMER];
	assign spi_clk_en   = en_ff[smcg_pkg::SMCG_EN_SPI];
	assign irq_clk_en   = en_ff[smcg_pkg::SMCG_EN_IRQ];
	assign io_clk_en    = en_ff[smcg_pkg::SMCG_EN_IO];
	assign adc_clk_en   = en_ff[smcg_pkg::SMCG_EN_ADC];
	assign async_clk_en = en_ff[smcg_pkg::SMCG_EN_ASYNC];
	assign xosc_en      = en_ff[smcg_pkg::SMCG_EN_XOSC];
	assign rcosc_en     = en_ff[smcg_pkg::SMCG_EN_RCOSC];
	assign core_pwr_en  = pwr_ff[smcg_pkg::SMCG_PD_CORE];
	assign io_pwr_en    = pwr_ff[smcg_pkg::SMCG_PD_IO];
	assign wdt_run      = run_ff[0];
	assign symcnt_run   = run_ff[1];
	assign lfosc_run    = run_ff[2];
	assign sleeping     = sleep_ff;
	assign mode_err     = err_ff;
endmodule : smcg_top

// file: tb/smcg_chk.sv
// checker of sleep entry, wake restore and illegal mode handling
`timescale 1ns/100ps
module smcg_chk (
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic [2:0] mode_sel,
	input wire logic       sleep_req,
	input wire logic       deep_req,
	input wire logic       keep_wdt,
	input wire logic       wake_irq,
	input wire logic       cpu_clk_en,
	input wire logic       ram_clk_en,
	input wire logic       timer_clk_en,
	input wire logic       spi_clk_en,
	input wire logic       irq_clk_en,
	input wire logic       io_clk_en,
	input wire logic       adc_clk_en,
	input wire logic       async_clk_en,
	input wire logic       xosc_en,
	input wire logic       rcosc_en,
	input wire logic       core_pwr_en,
	input wire logic       io_pwr_en,
	input wire logic       wdt_run,
	input wire logic       sleeping,
	input wire logic       mode_err
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// active state and a taken sleep request
	wire act  = !sleeping && cpu_clk_en;
	wire take = act && sleep_req && !deep_req;
	property p_idle;
		take && mode_sel == 3'h0 |=>
			ram_clk_en && timer_clk_en && spi_clk_en && irq_clk_en && !cpu_clk_en;
	endproperty
	a_idle: assert property (p_idle) else $error("idle gating wrong");
	property p_pdown; take && mode_sel == 3'h2 |=> sleeping && !xosc_en && !cpu_clk_en; endproperty
	a_pdown: assert property (p_pdown) else $error("power-down gating wrong");
	property p_save; take && mode_sel == 3'h3 |=> async_clk_en && !cpu_clk_en; endproperty
	a_save: assert property (p_save) else $error("power-save timer stopped");
	property p_nr;
		take && mode_sel == 3'h1 |=> !io_clk_en && adc_clk_en && async_clk_en;
	endproperty
	a_nr: assert property (p_nr) else $error("noise reduction gating wrong");
	property p_stby; take && mode_sel[2:1] == 2'h2 |=> rcosc_en && !cpu_clk_en; endproperty
	a_stby: assert property (p_stby) else $error("standby rc oscillator stopped");
	property p_deep;
		act && deep_req |=>
			sleeping && !core_pwr_en && !io_pwr_en && wdt_run == $past(keep_wdt);
	endproperty
	a_deep: assert property (p_deep) else $error("deep sleep supply wrong");
	property p_wake;
		sleeping && wake_irq |=>
			(!sleeping && !cpu_clk_en && ram_clk_en && core_pwr_en)[*4] ##1 cpu_clk_en;
	endproperty
	a_wake: assert property (p_wake) else $error("wake restore wrong");
	property p_err; take && mode_sel > 3'h5 |=> mode_err && !sleeping; endproperty
	a_err: assert property (p_err) else $error("illegal mode not refused");
	property p_err_cause; mode_err |-> $past(sleep_req) && $past(mode_sel) > 3'h5; endproperty
	a_err_cause: assert property (p_err_cause) else $error("spurious mode error");
	c_pdown: cover property (take && mode_sel == 3'h2);
	c_deep: cover property (act && deep_req);
	c_err: cover property (mode_err);
endmodule : smcg_chk
bind smcg_top smcg_chk u_chk (.*);

// file: tb/smcg_top_bench.sv
// self-checking bench of the sleep-mode manager
`timescale 1ns/100ps
module smcg_top_bench;
	logic       clk = 0, rstn = 0, sleep_req = 0, deep_req = 0, wake_irq = 0;
	logic       keep_wdt = 0, keep_symcnt = 0, keep_lfosc = 0;
	logic [2:0] mode_sel = 3'h0;
	logic       cpu_clk_en, ram_clk_en, timer_clk_en, spi_clk_en, irq_clk_en, io_clk_en;
	logic       adc_clk_en, async_clk_en, xosc_en, rcosc_en, core_pwr_en, io_pwr_en;
	logic       wdt_run, symcnt_run, lfosc_run, sleeping, mode_err;
	logic [9:0] en;
	int         failures = 0;
	int         total_checks = 0;
	// mask and value of the stated gates per mode
	logic [9:0] msk [6] = '{10'h01F, 10'h0ED, 10'h3FF, 10'h081, 10'h201, 10'h281};
	logic [9:0] val [6] = '{10'h01E, 10'h0C0, 10'h000, 10'h080, 10'h200, 10'h280};
	assign en = {rcosc_en, xosc_en, async_clk_en, adc_clk_en, io_clk_en, irq_clk_en,
		spi_clk_en, timer_clk_en, ram_clk_en, cpu_clk_en};
	smcg_top dut (.*);
	always #25 clk = ~clk;
	// compare seen and expected
	task chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask : chk
	task results();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results
	// one-cycle request, then settle after the taking edge
	task req(input logic [2:0] m, input logic d, input logic [2:0] k);
		@(posedge clk) begin
			sleep_req <= !d;
			deep_req <= d;
			mode_sel <= m;
			{keep_wdt, keep_symcnt, keep_lfosc} <= k;
		end
		@(posedge clk) begin
			sleep_req <= 0;
			deep_req <= 0;
		end
		@(negedge clk);
	endtask : req
	// wake pulse and restore sequence
	task wake();
		int i;
		@(posedge clk) wake_irq <= 1;
		@(posedge clk) wake_irq <= 0;
		@(negedge clk);
		chk(sleeping, 0);
		chk({core_pwr_en, io_pwr_en, wdt_run, symcnt_run, lfosc_run, en}, 16'h63FE);
		for (i = 0; i < 3; i++) begin
			@(negedge clk);
			chk(cpu_clk_en, 0);
		end
		@(negedge clk);
		chk(cpu_clk_en, 1);
	endtask : wake
	// every legal mode, back to back
	task t_modes();
		int m;
		for (m = 0; m < 6; m++) begin
			req(m[2:0], 0, 3'h0);
			chk(sleeping, 1);
			chk(en & msk[m], val[m]);
			chk({core_pwr_en, io_pwr_en}, 2'h3);
			wake();
		end
	endtask : t_modes
	// deep sleep with two keeper patterns
	task t_deep();
		int k;
		for (k = 2; k < 6; k += 3) begin
			req(3'h0, 1, k[2:0]);
			chk({core_pwr_en, io_pwr_en, en}, 12'h000);
			chk({wdt_run, symcnt_run, lfosc_run}, k[2:0]);
			wake();
		end
	endtask : t_deep
	// codes six and seven are refused
	task t_illegal();
		int m;
		for (m = 6; m < 8; m++) begin
			req(m[2:0], 0, 3'h0);
			chk({mode_err, sleeping, cpu_clk_en}, 3'h5);
			@(negedge clk);
			chk(mode_err, 0);
		end
	endtask : t_illegal
	// watchdog against a hang
	initial begin
		#(50 * 3000);
		failures++;
		results();
	end
	initial begin
		repeat (5) @(posedge clk);
		@(negedge clk);
		chk({core_pwr_en, io_pwr_en, wdt_run, symcnt_run, lfosc_run, en}, 16'h63FF);
		chk({sleeping, mode_err}, 2'h0);
		@(posedge clk) rstn <= 1;
		t_modes();
		t_deep();
		t_illegal();
		results();
	end
endmodule : smcg_top_bench
